// [mqf_pkg.sv]
package mqf_pkg;
  localparam int          WORD_W    = 18;
  localparam int          ADDR_W    = 12;
  localparam int          DEPTH     = 4096;
  localparam int          NUM_Q     = 3;
  localparam int          CNT_W     = 10;
  localparam int          IDX_W     = 6;
  localparam int          PROG_W    = 9;
  localparam logic [12:0] MEM_WORDS = 13'h1000;
  localparam logic [4:0]  Q1_MAX    = 5'h10;
  localparam logic [5:0]  CELL_MIN  = 6'h0A;
  localparam logic [5:0]  CELL_MAX  = 6'h20;
  localparam logic [3:0]  Q3_MAX    = 4'hF;
  localparam logic [8:0]  Q3_LEVEL_MASK = 9'h0FF;

  // auxiliary bus access order; each read or write steps to the next entry
  typedef enum logic [3:0] {
    ACC_FORMAT   = 4'h0,
    ACC_Q1_LEN   = 4'h1,
    ACC_Q2_LEN   = 4'h2,
    ACC_CELL_LEN = 4'h3,
    ACC_SET1     = 4'h4,
    ACC_CLR1     = 4'h5,
    ACC_SET2     = 4'h6,
    ACC_CLR2     = 4'h7,
    ACC_SET3     = 4'h8,
    ACC_CLR3     = 4'h9,
    ACC_Q3_LEN   = 4'hA
  } mqf_acc_t;

  typedef struct packed {
    logic [4:0]      busFormat;
    logic [4:0]      q1Len;
    logic [3:0]      q2Len;
    logic [5:0]      cellLen;
    logic [2:0][8:0] setLevel;
    logic [2:0][8:0] clrLevel;
  } mqf_cfg_t;

  localparam mqf_cfg_t CFG_RST = '{busFormat: 5'h00, q1Len: 5'h08, q2Len: 4'h6, cellLen: 6'h1B,
                                   setLevel: {9'h00D, 9'h033, 9'h047},
                                   clrLevel: {9'h00C, 9'h032, 9'h046}};

  typedef struct packed {
    logic       write;
    logic       read;
    logic [8:0] data;
  } mqf_prog_t;

  function automatic logic [25:0] qSpan(input mqf_cfg_t c, input int q);
    logic [12:0] a;
    logic [12:0] b;
    a = {c.q1Len, 8'h00};
    b = {1'b0, c.q2Len, 8'h00};
    if (a > MEM_WORDS) a = MEM_WORDS;
    if (b > MEM_WORDS - a) b = MEM_WORDS - a;
    case (q)
      0:       return {13'h0000, a};
      1:       return {a, b};
      default: return {13'(a + b), 13'(MEM_WORDS - a - b)};
    endcase
  endfunction

  function automatic logic [9:0] bin2gray(input logic [9:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [9:0] gray2bin(input logic [9:0] g);
    logic [9:0] b;
    b[9] = g[9];
    for (int i = 8; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction
endpackage

// [mqf_fifo.sv]
`timescale 1ns/1ns
module mqf_fifo (
  input  wire logic                clk,                // write side clock
  input  wire logic                rst,                // synchronous reset, high
  input  wire logic [2:0]          queueWriteEnable,   // one enable per queue
  input  wire logic [17:0]         writeData,          // word to store
  input  wire logic                inputCellStartMark, // first word of cell
  input  wire logic                alarmClearInput,    // clears framing alarm
  output logic [2:0]               queueFullFlagN,     // low: no room for a cell
  output logic [2:0]               fillFlagN,          // programmable fill flags
  output logic                     cellFramingAlarmN,  // low: framing fault
  input  wire logic                readClk,            // read side clock
  input  wire logic                readStrobeEnable,   // read request
  input  wire logic                readQueueSelectLo,  // queue select bit 0
  input  wire logic                readQueueSelectHi,  // queue select bit 1
  output logic [17:0]              readData,           // word read out
  output logic                     readDataValid,      // readData new this cycle
  output logic [2:0]               cellReady,          // queue holds a full cell
  input  wire mqf_pkg::mqf_prog_t  progIn,             // aux bus strobes and data
  output logic [8:0]               progDataOut         // aux bus read data
);
  typedef struct packed {
    mqf_pkg::mqf_cfg_t cfg;
    mqf_pkg::mqf_acc_t acc;
    logic [8:0]        progOut;
    logic [2:0][9:0]   cellsIn;
    logic [2:0][9:0]   inGray;
    logic [2:0][5:0]   wIdx;
    logic [2:0][11:0]  wOff;
    logic [2:0][11:0]  wStart;
    logic [2:0][9:0]   outSync1;
    logic [2:0][9:0]   outSync2;
    logic [2:0]        fullN;
    logic [2:0]        fillN;
    logic              alarmN;
  } mqf_wr_t;

  typedef struct packed {
    mqf_pkg::mqf_cfg_t cfgSync1;
    mqf_pkg::mqf_cfg_t cfgSync2;
    logic [2:0][9:0]   inSync1;
    logic [2:0][9:0]   inSync2;
    logic [2:0][9:0]   cellsOut;
    logic [2:0][9:0]   outGray;
    logic [2:0][5:0]   rIdx;
    logic [2:0][11:0]  rOff;
    logic [17:0]       dataOut;
    logic              dataValid;
    logic [2:0]        ready;
  } mqf_rd_t;

  mqf_wr_t wr_r;
  mqf_wr_t wr_nxt;
  mqf_rd_t rd_r;
  mqf_rd_t rd_nxt;
  logic [17:0] mem [mqf_pkg::DEPTH];
  logic        memWe;
  logic [11:0] memAddr;
  logic        rdRstS1_r;
  logic        rdRst_r;

  logic [2:0][12:0] wBase;
  logic [2:0][12:0] wSize;
  logic [2:0][12:0] rBase;
  logic [2:0][12:0] rSize;
  logic [2:0][9:0]  held;
  logic [2:0]       room;
  logic [2:0]       avail;
  logic [3:0]       q3LenRead;

  // per-queue geometry and occupancy
  genvar g;
  generate
    for (g = 0; g < mqf_pkg::NUM_Q; g++)
    begin : gQueue
      logic [15:0] used;
      assign {wBase[g], wSize[g]} = mqf_pkg::qSpan(wr_r.cfg, g);
      assign {rBase[g], rSize[g]} = mqf_pkg::qSpan(rd_r.cfgSync2, g);
      assign held[g]  = 10'(wr_r.cellsIn[g] - mqf_pkg::gray2bin(wr_r.outSync2[g]));
      assign used     = 16'(held[g] * wr_r.cfg.cellLen);
      assign room[g]  = (17'(used) + 17'(wr_r.cfg.cellLen)) <= 17'(wSize[g]);
      assign avail[g] = mqf_pkg::gray2bin(rd_r.inSync2[g]) != rd_r.cellsOut[g];
    end
  endgenerate

  // queue three takes what queues one and two leave
  assign q3LenRead = (wSize[2][12]) ? mqf_pkg::Q3_MAX : wSize[2][11:8];

  // ---------------- write clock domain ----------------
  logic       wOneHot;
  logic [1:0] wq;
  logic       frameErr;
  logic       wAccept;
  logic [11:0] offInc;
  logic [8:0] progVal;

  always_comb
  begin
    wr_nxt  = wr_r;
    memWe   = 1'b0;
    memAddr = 12'h000;
    wOneHot = $onehot(queueWriteEnable);
    case (queueWriteEnable)
      3'b010:  wq = 2'd1;
      3'b100:  wq = 2'd2;
      default: wq = 2'd0;
    endcase
    // start mark judged only where the word could be stored
    frameErr = wOneHot && wr_r.alarmN && ((wr_r.wIdx[wq] != 6'h00) || room[wq]) &&
               (inputCellStartMark != (wr_r.wIdx[wq] == 6'h00));
    // store only on a single enable with room
    wAccept  = wOneHot && wr_r.alarmN && !frameErr &&
               ((wr_r.wIdx[wq] != 6'h00) || room[wq]);
    offInc   = 12'(wr_r.wOff[wq] + 12'h001);
    if (13'(offInc) == wSize[wq])
      offInc = 12'h000;
    if (wAccept)
    begin
      memWe             = 1'b1;
      memAddr           = 12'(wBase[wq] + 13'(wr_r.wOff[wq]));
      wr_nxt.wOff[wq]   = offInc;
      if (wr_r.wIdx[wq] == 6'(wr_r.cfg.cellLen - 6'h01))
      begin
        wr_nxt.wIdx[wq]    = 6'h00;
        wr_nxt.cellsIn[wq] = 10'(wr_r.cellsIn[wq] + 10'h001);
        wr_nxt.wStart[wq]  = offInc;
      end
      else
        wr_nxt.wIdx[wq] = 6'(wr_r.wIdx[wq] + 6'h01);
    end
    // clear drops partial cells; a new fault wins over the clear
    if (alarmClearInput)
    begin
      wr_nxt.alarmN = 1'b1;
      wr_nxt.wIdx   = '0;
      wr_nxt.wOff   = wr_nxt.wStart;
    end
    if (frameErr)
      wr_nxt.alarmN = 1'b0;
    for (int q = 0; q < mqf_pkg::NUM_Q; q++)
    begin
      wr_nxt.inGray[q] = mqf_pkg::bin2gray(wr_nxt.cellsIn[q]);
      wr_nxt.fullN[q]  = room[q];
      // set level drives the flag low
      if (held[q] >= 10'(wr_r.cfg.setLevel[q]))
        wr_nxt.fillN[q] = 1'b0;
      else if (held[q] <= 10'(wr_r.cfg.clrLevel[q]))
        wr_nxt.fillN[q] = 1'b1;
    end
    // read-side cell count crosses as gray code
    wr_nxt.outSync1 = rd_r.outGray;
    wr_nxt.outSync2 = wr_r.outSync1;

    case (wr_r.acc)
      mqf_pkg::ACC_FORMAT:   progVal = {4'h0, wr_r.cfg.busFormat};
      mqf_pkg::ACC_Q1_LEN:   progVal = {4'h0, wr_r.cfg.q1Len};
      mqf_pkg::ACC_Q2_LEN:   progVal = {5'h00, wr_r.cfg.q2Len};
      mqf_pkg::ACC_CELL_LEN: progVal = {3'h0, wr_r.cfg.cellLen};
      mqf_pkg::ACC_SET1:     progVal = wr_r.cfg.setLevel[0];
      mqf_pkg::ACC_CLR1:     progVal = wr_r.cfg.clrLevel[0];
      mqf_pkg::ACC_SET2:     progVal = wr_r.cfg.setLevel[1];
      mqf_pkg::ACC_CLR2:     progVal = wr_r.cfg.clrLevel[1];
      mqf_pkg::ACC_SET3:     progVal = wr_r.cfg.setLevel[2];
      mqf_pkg::ACC_CLR3:     progVal = wr_r.cfg.clrLevel[2];
      mqf_pkg::ACC_Q3_LEN:   progVal = {5'h00, q3LenRead};
      default:               progVal = 9'h000;
    endcase
    if (progIn.write)
    begin
      case (wr_r.acc)
        mqf_pkg::ACC_FORMAT:   wr_nxt.cfg.busFormat = progIn.data[4:0];
        mqf_pkg::ACC_Q1_LEN:
          if (progIn.data[4:0] <= mqf_pkg::Q1_MAX)
            wr_nxt.cfg.q1Len = progIn.data[4:0];
        mqf_pkg::ACC_Q2_LEN:   wr_nxt.cfg.q2Len = progIn.data[3:0];
        // cell length, out of range ignored
        mqf_pkg::ACC_CELL_LEN:
          if (progIn.data[5:0] >= mqf_pkg::CELL_MIN && progIn.data[5:0] <= mqf_pkg::CELL_MAX)
            wr_nxt.cfg.cellLen = progIn.data[5:0];
        mqf_pkg::ACC_SET1:     wr_nxt.cfg.setLevel[0] = progIn.data;
        mqf_pkg::ACC_CLR1:     wr_nxt.cfg.clrLevel[0] = progIn.data;
        mqf_pkg::ACC_SET2:     wr_nxt.cfg.setLevel[1] = progIn.data;
        mqf_pkg::ACC_CLR2:     wr_nxt.cfg.clrLevel[1] = progIn.data;
        mqf_pkg::ACC_SET3:     wr_nxt.cfg.setLevel[2] = progIn.data & mqf_pkg::Q3_LEVEL_MASK;
        mqf_pkg::ACC_CLR3:     wr_nxt.cfg.clrLevel[2] = progIn.data & mqf_pkg::Q3_LEVEL_MASK;
        default:               wr_nxt.cfg = wr_r.cfg;
      endcase
    end
    else if (progIn.read)
      wr_nxt.progOut = progVal;
    if (progIn.write || progIn.read)
      wr_nxt.acc = (wr_r.acc == mqf_pkg::ACC_Q3_LEN) ? mqf_pkg::ACC_FORMAT
                                                      : mqf_pkg::mqf_acc_t'(wr_r.acc + 4'h1);
    if (rst)
    begin
      wr_nxt        = '0;
      wr_nxt.cfg    = mqf_pkg::CFG_RST;
      wr_nxt.acc    = mqf_pkg::ACC_FORMAT;
      wr_nxt.fillN  = 3'b111;
      wr_nxt.fullN  = 3'b111;
      wr_nxt.alarmN = 1'b1;
      memWe         = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    wr_r <= wr_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[memAddr] <= writeData;
  end

  assign queueFullFlagN    = wr_r.fullN;
  assign fillFlagN         = wr_r.fillN;
  assign cellFramingAlarmN = wr_r.alarmN;
  assign progDataOut       = wr_r.progOut;

  // ---------------- read clock domain ----------------
  // reset reaches the read side after two read clock edges
  always_ff @(posedge readClk)
  begin
    rdRstS1_r <= rst;
    rdRst_r   <= rdRstS1_r;
  end

  logic [1:0]  rq;
  logic        rAccept;
  logic [11:0] rOffInc;

  always_comb
  begin
    rd_nxt = rd_r;
    // select 00 is queue one, 11 selects nothing
    rq     = {readQueueSelectHi, readQueueSelectLo};
    // read only a queue holding a whole cell
    rAccept = readStrobeEnable && (rq != 2'b11) && avail[rq];
    rOffInc = 12'(rd_r.rOff[rq] + 12'h001);
    if (13'(rOffInc) == rSize[rq])
      rOffInc = 12'h000;
    rd_nxt.dataValid = rAccept;
    if (rAccept)
    begin
      rd_nxt.dataOut  = mem[12'(rBase[rq] + 13'(rd_r.rOff[rq]))];
      rd_nxt.rOff[rq] = rOffInc;
      if (rd_r.rIdx[rq] == 6'(rd_r.cfgSync2.cellLen - 6'h01))
      begin
        rd_nxt.rIdx[rq]     = 6'h00;
        rd_nxt.cellsOut[rq] = 10'(rd_r.cellsOut[rq] + 10'h001);
      end
      else
        rd_nxt.rIdx[rq] = 6'(rd_r.rIdx[rq] + 6'h01);
    end
    for (int q = 0; q < mqf_pkg::NUM_Q; q++)
      rd_nxt.outGray[q] = mqf_pkg::bin2gray(rd_nxt.cellsOut[q]);
    // cell ready on the read clock
    rd_nxt.ready    = avail;
    // write-side counts and static settings cross here
    rd_nxt.inSync1  = wr_r.inGray;
    rd_nxt.inSync2  = rd_r.inSync1;
    rd_nxt.cfgSync1 = wr_r.cfg;
    rd_nxt.cfgSync2 = rd_r.cfgSync1;
    if (rdRst_r)
    begin
      rd_nxt          = '0;
      rd_nxt.cfgSync1 = wr_r.cfg;
      rd_nxt.cfgSync2 = rd_r.cfgSync1;
    end
  end

  always_ff @(posedge readClk)
  begin
    rd_r <= rd_nxt;
  end

  assign readData      = rd_r.dataOut;
  assign readDataValid = rd_r.dataValid;
  assign cellReady     = rd_r.ready;

  // ---------------- checks ----------------
  property p_writeNeedsOne;
    @(posedge clk) disable iff (rst) memWe |-> $onehot(queueWriteEnable) && cellFramingAlarmN;
  endproperty
  a_writeNeedsOne: assert property (p_writeNeedsOne) else $error("write with bad enables");

  property p_idleNoMove;
    @(posedge clk) disable iff (rst)
      (queueWriteEnable == 3'b000) && !alarmClearInput |=> wr_r.wOff == $past(wr_r.wOff);
  endproperty
  a_idleNoMove: assert property (p_idleNoMove) else $error("write pointer moved while idle");

  property p_fullRefused;
    @(posedge clk) disable iff (rst)
      (queueWriteEnable == 3'b001) && !room[0] && (wr_r.wIdx[0] == 6'h00) |-> !memWe;
  endproperty
  a_fullRefused: assert property (p_fullRefused) else $error("write into full queue");

  property p_fullFlag;
    @(posedge clk) disable iff (rst) !room[1] |=> !queueFullFlagN[1];
  endproperty
  a_fullFlag: assert property (p_fullFlag) else $error("full flag not low");

  property p_fillSet;
    @(posedge clk) disable iff (rst) held[0] >= 10'(wr_r.cfg.setLevel[0]) |=> !fillFlagN[0];
  endproperty
  a_fillSet: assert property (p_fillSet) else $error("fill flag one not low");

  property p_fillClear;
    @(posedge clk) disable iff (rst)
      held[0] < 10'(wr_r.cfg.setLevel[0]) && held[0] <= 10'(wr_r.cfg.clrLevel[0]) |=> fillFlagN[0];
  endproperty
  a_fillClear: assert property (p_fillClear) else $error("fill flag one not high");

  property p_alarmHold;
    @(posedge clk) disable iff (rst) frameErr ##1 !alarmClearInput[*2] |-> !cellFramingAlarmN;
  endproperty
  a_alarmHold: assert property (p_alarmHold) else $error("alarm dropped without clear");

  property p_cfgDefault;
    @(posedge clk) rst |=> wr_r.cfg.q1Len == 5'h08 && wr_r.cfg.cellLen == 6'h1B;
  endproperty
  a_cfgDefault: assert property (p_cfgDefault) else $error("bad settings after reset");

  property p_readIgnored;
    @(posedge readClk) disable iff (rdRst_r)
      readStrobeEnable && (rq == 2'b00) && !avail[0] |=> !readDataValid && $stable(rd_r.rOff[0]);
  endproperty
  a_readIgnored: assert property (p_readIgnored) else $error("read from empty queue");

  property p_readValid;
    @(posedge readClk) disable iff (rdRst_r) rAccept |=> readDataValid ##1 (readDataValid == $past(rAccept));
  endproperty
  a_readValid: assert property (p_readValid) else $error("read word not presented");

  property p_readyTracks;
    @(posedge readClk) disable iff (rdRst_r) avail[2] |=> cellReady[2];
  endproperty
  a_readyTracks: assert property (p_readyTracks) else $error("cell ready missed");
endmodule

// [mqf_reader.sv]
`timescale 1ns/1ns
module mqf_reader (
  input  wire logic        readClk,           // read side clock
  input  wire logic        readDataValid,     // word delivered
  input  wire logic [17:0] readData,          // delivered word
  output logic             readStrobeEnable,  // read request
  output logic             readQueueSelectLo, // select bit 0
  output logic             readQueueSelectHi  // select bit 1
);
  int          want = 0;
  logic        slow = 1'b0;
  logic [1:0]  sel  = 2'h0;
  logic        skip = 1'b0;
  logic [17:0] got[$];

  initial
  begin
    readStrobeEnable = 1'b0;
    {readQueueSelectHi, readQueueSelectLo} = 2'h0;
  end

  always @(negedge readClk)
  begin
    skip <= slow & ~skip;
    {readQueueSelectHi, readQueueSelectLo} <= sel;
    if (want > 0 && !(slow && skip))
    begin
      readStrobeEnable <= 1'b1;
      want <= want - 1;
    end
    else
      readStrobeEnable <= 1'b0;
  end

  always @(posedge readClk)
    if (readDataValid === 1'b1)
      got.push_back(readData);
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               readClk = 1'b0;
  logic [2:0]         queueWriteEnable = 3'h0;
  logic [17:0]        writeData = 18'h00000;
  logic               inputCellStartMark = 1'b0;
  logic               alarmClearInput = 1'b0;
  logic [2:0]         queueFullFlagN;
  logic [2:0]         fillFlagN;
  logic               cellFramingAlarmN;
  logic               readStrobeEnable;
  logic               readQueueSelectLo;
  logic               readQueueSelectHi;
  logic [17:0]        readData;
  logic               readDataValid;
  logic [2:0]         cellReady;
  mqf_pkg::mqf_prog_t progIn = '0;
  logic [8:0]         progDataOut;
  int                 n_mismatch = 0;
  int                 total_checks = 0;
  int                 cl = 27;

  initial forever #4 clk = ~clk;
  initial
  begin
    #3;
    forever #40 readClk = ~readClk;
  end

  mqf_fifo mqf_fifo_i (.clk(clk), .rst(rst), .queueWriteEnable(queueWriteEnable), .writeData(writeData),
    .inputCellStartMark(inputCellStartMark), .alarmClearInput(alarmClearInput), .queueFullFlagN(queueFullFlagN),
    .fillFlagN(fillFlagN), .cellFramingAlarmN(cellFramingAlarmN), .readClk(readClk),
    .readStrobeEnable(readStrobeEnable), .readQueueSelectLo(readQueueSelectLo),
    .readQueueSelectHi(readQueueSelectHi), .readData(readData), .readDataValid(readDataValid),
    .cellReady(cellReady), .progIn(progIn), .progDataOut(progDataOut));

  mqf_reader mqf_reader_i (.readClk(readClk), .readDataValid(readDataValid), .readData(readData),
    .readStrobeEnable(readStrobeEnable), .readQueueSelectLo(readQueueSelectLo),
    .readQueueSelectHi(readQueueSelectHi));

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [17:0] wd(input int q, input int c, input int w);
    return {2'(q), 8'(c), 8'(w)};
  endfunction

  // mk is the word index that carries the start mark
  task automatic put_cell(input int q, input int c, input int mk);
    for (int w = 0; w < cl; w++)
    begin
      @(negedge clk);
      queueWriteEnable = 3'(1 << q);
      writeData = wd(q, c, w);
      inputCellStartMark = (w == mk);
    end
    @(negedge clk);
    queueWriteEnable = 3'h0;
    inputCellStartMark = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic aux(input logic w, input logic [8:0] d);
    @(negedge clk);
    progIn = '{write: w, read: ~w, data: d};
    @(negedge clk);
    progIn = '0;
    @(negedge clk);
  endtask

  task automatic wr_pass(input logic [8:0] v[11]);
    for (int i = 0; i < 11; i++)
      aux(1'b1, v[i]);
  endtask

  task automatic rd_pass(input logic [8:0] v[11]);
    for (int i = 0; i < 11; i++)
    begin
      aux(1'b0, 9'h000);
      chk($sformatf("setting %0d", i), 18'(v[i]), 18'(progDataOut));
    end
  endtask

  task automatic rd(input logic [1:0] s, input int nw, input int nc, input int q, input int c0);
    int k;
    mqf_reader_i.got.delete();
    mqf_reader_i.sel = s;
    mqf_reader_i.want = nw;
    k = 0;
    while (mqf_reader_i.want != 0 && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
    repeat (3) @(posedge readClk);
    @(negedge clk);
    chk("read count", 18'(nc * cl), 18'(mqf_reader_i.got.size()));
    for (int i = 0; i < nc * cl && i < mqf_reader_i.got.size(); i++)
      chk("read word", wd(q, c0 + i / cl, i % cl), mqf_reader_i.got[i]);
  endtask

  task automatic wait_ready(input int q);
    for (int k = 0; k < 200 && cellReady[q] !== 1'b1; k++)
      @(negedge clk);
    chk("cell ready", 18'h1, 18'(cellReady[q]));
  endtask

  task automatic t_config;
    chk("reset flags", 18'h003F8, 18'({queueFullFlagN, fillFlagN, cellFramingAlarmN, cellReady}));
    rd_pass('{9'h000, 9'h008, 9'h006, 9'h01B, 9'h047, 9'h046, 9'h033, 9'h032, 9'h00D, 9'h00C, 9'h002});
    // out-of-range lengths refused, narrow levels masked
    wr_pass('{9'h015, 9'h011, 9'h001, 9'h009, 9'h003, 9'h001, 9'h003, 9'h001, 9'h1FF, 9'h001, 9'h007});
    rd_pass('{9'h015, 9'h008, 9'h001, 9'h01B, 9'h003, 9'h001, 9'h003, 9'h001, 9'h0FF, 9'h001, 9'h007});
    wr_pass('{9'h000, 9'h001, 9'h001, 9'h00A, 9'h003, 9'h001, 9'h003, 9'h001, 9'h003, 9'h001, 9'h000});
    rd_pass('{9'h000, 9'h001, 9'h001, 9'h00A, 9'h003, 9'h001, 9'h003, 9'h001, 9'h003, 9'h001, 9'h00E});
    cl = 10;
  endtask

  task automatic t_fill;
    for (int c = 0; c < 25; c++)
    begin
      put_cell(0, c, 0);
      if (c == 1)
        chk("fill below set", 18'h1, 18'(fillFlagN[0]));
      if (c == 2)
        chk("fill at set", 18'h0, 18'(fillFlagN[0]));
      if (c == 23)
        chk("room left", 18'h1, 18'(queueFullFlagN[0]));
    end
    chk("queue full", 18'h0, 18'(queueFullFlagN[0]));
    chk("idle reads", 18'h0, 18'(mqf_reader_i.got.size()));
    put_cell(0, 25, 0);
    chk("alarm quiet on refused cell", 18'h1, 18'(cellFramingAlarmN));
    mqf_reader_i.slow = 1'b1;
    rd(2'h0, 230, 23, 0, 0);
    mqf_reader_i.slow = 1'b0;
    repeat (20) @(negedge clk);
    chk("room again", 18'h1, 18'(queueFullFlagN[0]));
    chk("fill held", 18'h0, 18'(fillFlagN[0]));
    rd(2'h0, 10, 1, 0, 23);
    repeat (20) @(negedge clk);
    chk("fill at clear", 18'h1, 18'(fillFlagN[0]));
    rd(2'h0, 10, 1, 0, 24);
    chk("ready drop", 18'h0, 18'(cellReady[0]));
    rd(2'h0, 10, 0, 0, 0);
  endtask

  task automatic t_queues;
    put_cell(1, 0, 0);
    put_cell(2, 0, 0);
    wait_ready(1);
    wait_ready(2);
    chk("other ready", 18'h0, 18'(cellReady[0]));
    chk("queue two three flags", 18'hF, 18'({queueFullFlagN[2:1], fillFlagN[2:1]}));
    rd(2'h2, 10, 1, 2, 0);
    rd(2'h1, 10, 1, 1, 0);
    rd(2'h3, 10, 0, 0, 0);
  endtask

  task automatic t_alarm;
    put_cell(0, 30, 3);
    chk("alarm set", 18'h0, 18'(cellFramingAlarmN));
    put_cell(0, 31, 0);
    @(negedge clk);
    alarmClearInput = 1'b1;
    @(negedge clk);
    alarmClearInput = 1'b0;
    @(negedge clk);
    chk("alarm clear", 18'h1, 18'(cellFramingAlarmN));
    put_cell(0, 32, 0);
    wait_ready(0);
    rd(2'h0, 20, 1, 0, 32);
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    repeat (4) @(posedge readClk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(posedge readClk);
    @(negedge clk);
    t_config;
    t_fill;
    t_queues;
    t_alarm;
    wrap_up;
  end

  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
endmodule
